// [dv/pci_master_target_port_properties.sv]
`timescale 1ns/1ps
module pci_master_target_port_properties (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe,
  input wire logic [3:0]  ctl,
  input wire logic [3:0]  dev_ctl_oe,
  input wire logic        dev_ad_oe,
  input wire logic        host_ad_oe,
  input wire logic        par
);
  // ctl bits: 0 frame, 1 irdy, 2 trdy, 3 devsel, all active low
  logic fr_q;
  logic ir_q;
  logic st;
  logic win;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fr_q <= 1'b1;
      ir_q <= 1'b1;
    end else begin
      fr_q <= ctl[0];
      ir_q <= ctl[1];
    end
  end
  // address cycle: frame just fell, so chained starts count too
  assign st = !ctl[0] && fr_q;
  assign win = ad[31:16] == pci_pkg::REG_WIN || ad[31:16] == pci_pkg::LPB_WIN;
  ////////////////////////////////////////////////////////////////////////////
  a_par_low: assert property (par == 1'b0)
    else $error("par not held low");
  a_trdy_devsel: assert property (!ctl[2] |-> !ctl[3])
    else $error("trdy without devsel");
  a_frame_irdy: assert property ($rose(ctl[0]) |-> !ctl[1])
    else $error("frame released without irdy");
  a_rd_turn: assert property (st && !cbe[0] |=> !dev_ad_oe && !host_ad_oe)
    else $error("no read turnaround");
  a_wr_data: assert property (st && cbe[0] |=> dev_ad_oe || host_ad_oe)
    else $error("write data not driven");
  a_cfg_rd: assert property (st && cbe == pci_pkg::CMD_CFG_RD |=>
    ctl[2] [*3] ##1 !ctl[2])
    else $error("config read wait count");
  a_reg_rd: assert property (st && cbe == pci_pkg::CMD_MEM_RD && win
    |=> ctl[2] [*4] ##1 !ctl[2])
    else $error("register read wait count");
  a_wr_zero: assert property (st && (cbe == pci_pkg::CMD_CFG_WR ||
    cbe == pci_pkg::CMD_MEM_WR && win) |=> !ctl[3] && !ctl[2])
    else $error("target write waited");
  a_irdy_held: assert property (dev_ctl_oe[1] && !ctl[0] && !ctl[1] && !ctl[2]
    |=> !ctl[1])
    else $error("initiator wait inside burst");
  a_dma_first: assert property (st && dev_ctl_oe[0] && ir_q |=> !ctl[1])
    else $error("wait in first transaction");
  a_fbb_wait: assert property (st && dev_ctl_oe[0] && !ir_q
    |=> ctl[1] && cbe == pci_pkg::BE_NONE ##1 !ctl[1])
    else $error("chained start wait");
  cover property (st && cbe == pci_pkg::CMD_CFG_RD);
  cover property (st && cbe == pci_pkg::CMD_MEM_RD && win);
  cover property (st && dev_ctl_oe[0] && !ir_q);
endmodule

// [dv/tb_pci_master_target_port.sv]
`timescale 1ns/1ps
module tb_pci_master_target_port;
  logic            clk, resetn, dma_start, dma_write, dma_fbb, dma_busy, dma_take, dma_rvalid;
  logic            dma_done, tgt_req, tgt_we, cmd_start, cmd_busy, cmd_done, cmd_abort, mem_wr;
  logic [7:0]      dma_len;
  logic [31:0]     dma_addr, dma_wdata, dma_rdata, tgt_addr, tgt_wdata, tgt_rdata;
  logic [31:0]     cmd_addr, cmd_wdata, cmd_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [3:0]      tgt_be, cmd_code, cmd_be, mem_be;
  pci_pkg::space_t tgt_space;
  logic [31:0]     q_cmd[$], q_tgt[$], q_mem[$], q_dma[$];
  int              bad_count, check_count, dones;
  pci_if bus ();
  // host memory word is the inverted address, so read data proves the address
  assign mem_rdata = ~mem_addr;
  pci_device_end #(.LW(8)) u_pci_device_end (.clk(clk), .resetn(resetn), .bus(bus),
    .dma_start(dma_start), .dma_write(dma_write), .dma_fbb(dma_fbb), .dma_addr(dma_addr),
    .dma_len(dma_len), .dma_wdata(dma_wdata), .dma_busy(dma_busy), .dma_take(dma_take),
    .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata), .dma_done(dma_done), .tgt_req(tgt_req),
    .tgt_we(tgt_we), .tgt_space(tgt_space), .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata),
    .tgt_be(tgt_be), .tgt_rdata(tgt_rdata));
  pci_host_end u_pci_host_end (.clk(clk), .resetn(resetn), .bus(bus), .cmd_start(cmd_start),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be(cmd_be),
    .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_abort(cmd_abort), .cmd_rdata(cmd_rdata),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_rdata(mem_rdata));
  pci_master_target_port_properties u_props (.clk(clk), .resetn(resetn), .ad(bus.ad),
    .cbe(bus.cbe), .ctl(bus.ctl), .dev_ctl_oe(bus.dev_ctl_oe), .dev_ad_oe(bus.dev_ad_oe),
    .host_ad_oe(bus.host_ad_oe), .par(bus.par));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic hang(input string nm);
    $display("Error %s expected done seen timeout", nm);
    bad_count++;
    tally_and_finish();
  endtask
  task automatic hcmd(input logic [3:0] c, input logic [15:0] w);
    logic [31:0] r;
    logic        dn;
    int          n;
    r = $urandom;
    dn = 1'b0;
    @(posedge clk);
    if (c[0]) q_tgt.push_back(r); else q_cmd.push_back(r);
    cmd_code <= c;
    cmd_addr <= {w, r[15:2], 2'b00};
    cmd_wdata <= r;
    tgt_rdata <= r;
    cmd_start <= 1'b1;
    @(posedge clk);
    cmd_start <= 1'b0;
    for (n = 0; n < 100 && !(dn && cmd_busy === 1'b0); n++) begin
      @(negedge clk);
      dn = dn | (cmd_done === 1'b1);
    end
    if (n == 100) hang("cmd_done");
  endtask
  task automatic dstart(input logic wr, input logic fb, input logic [7:0] len);
    logic [31:0] a;
    int          n;
    a = {16'h0010, 16'($urandom) & 16'hfff0};
    for (n = 0; n < len; n++) if (!wr) q_dma.push_back(~(a + 32'(n) * 32'h4));
    @(posedge clk);
    dma_write <= wr;
    dma_fbb <= fb;
    dma_addr <= a;
    dma_len <= len;
    dma_start <= 1'b1;
    @(posedge clk);
    dma_start <= 1'b0;
    @(negedge clk);
    for (n = 0; n < 200 && dma_busy !== 1'b0; n++) @(negedge clk);
    if (n == 200) hang("dma_busy");
  endtask
  task automatic dwait(input int k);
    int n;
    for (n = 0; n < 400 && dones < k; n++) @(negedge clk);
    if (n == 400) hang("dma_done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // write words are noted when taken, the far end sees them later
  always @(posedge clk) begin
    if (dma_take === 1'b1) begin
      q_mem.push_back(dma_wdata);
      dma_wdata <= $urandom;
    end
  end
  always @(negedge clk) begin
    if (cmd_done === 1'b1) begin
      cmp("cmd_abort", 32'h0, {31'h0, cmd_abort});
      cmp("par", 32'h0, {31'h0, bus.par});
      if (q_cmd.size() > 0) cmp("cmd_rdata", q_cmd.pop_front(), cmd_rdata);
    end
    if (tgt_req === 1'b1 && tgt_we === 1'b1 && q_tgt.size() > 0)
      cmp("tgt_wdata", q_tgt.pop_front(), tgt_wdata);
    if (tgt_req === 1'b1 && tgt_we === 1'b1)
      cmp("tgt_be", 32'(pci_pkg::BE_ALL), {28'h0, tgt_be});
    if (mem_wr === 1'b1 && q_mem.size() > 0)
      cmp("mem_wdata", q_mem.pop_front(), mem_wdata);
    if (mem_wr === 1'b1) cmp("mem_be", 32'(pci_pkg::BE_ALL), {28'h0, mem_be});
    if (dma_rvalid === 1'b1 && q_dma.size() > 0)
      cmp("dma_rdata", q_dma.pop_front(), dma_rdata);
    if (dma_done === 1'b1) dones++;
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {resetn, dma_start, dma_write, dma_fbb, cmd_start} = 5'h0;
    {dma_len, dma_addr, dma_wdata, tgt_rdata, cmd_addr, cmd_wdata} = '0;
    cmd_code = 4'h0;
    cmd_be = pci_pkg::BE_ALL;
    void'($urandom(32'h0b4883d2));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // config, register and local bus, read then write, back to back
    for (int i = 0; i < 6; i++) begin
      hcmd({i < 2 ? 3'h5 : 3'h3, i[0]}, i < 2 ? 16'($urandom) : i < 4 ? pci_pkg::REG_WIN
        : pci_pkg::LPB_WIN);
    end
    $display("test host_access done");
    dstart(1'b1, 1'b0, 8'h3);
    dwait(1);
    dstart(1'b0, 1'b0, 8'(1 + $urandom % 4));
    dwait(2);
    $display("test dma_bursts done");
    dstart(1'b1, 1'b0, 8'h3);
    dstart(1'b0, 1'b1, 8'h2);
    dwait(4);
    $display("test chained done");
    tally_and_finish();
  end
endmodule

// [include/pci_if.sv]
`timescale 1ns/1ps
interface pci_if;
  logic [31:0] dev_ad_o;
  logic        dev_ad_oe;
  logic [3:0]  dev_cbe_o;
  logic        dev_cbe_oe;
  logic [3:0]  dev_ctl_o;
  logic [3:0]  dev_ctl_oe;
  logic        par_o;
  logic        par_oe;
  logic        req_n;
  logic [31:0] host_ad_o;
  logic        host_ad_oe;
  logic [3:0]  host_cbe_o;
  logic        host_cbe_oe;
  logic [3:0]  host_ctl_o;
  logic [3:0]  host_ctl_oe;
  logic        gnt_n;
  logic [31:0] ad;
  logic [3:0]  cbe;
  logic [3:0]  ctl;
  logic        par;

  // undriven lines float to the pulled-up idle level
  always_comb begin
    ad = dev_ad_oe ? dev_ad_o : host_ad_oe ? host_ad_o : pci_pkg::AD_IDLE;
    cbe = dev_cbe_oe ? dev_cbe_o : host_cbe_oe ? host_cbe_o : pci_pkg::BE_NONE;
    par = par_oe ? par_o : 1'b1;
    for (int i = 0; i < 4; i++) begin
      ctl[i] = dev_ctl_oe[i] ? dev_ctl_o[i] : host_ctl_oe[i] ? host_ctl_o[i] : 1'b1;
    end
  end

  modport dev (input ad, cbe, ctl, gnt_n,
               output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_ctl_o,
               dev_ctl_oe, par_o, par_oe, req_n);
  modport host (input ad, cbe, ctl, par, req_n,
                output host_ad_o, host_ad_oe, host_cbe_o, host_cbe_oe,
                host_ctl_o, host_ctl_oe, gnt_n);
endinterface

// [include/pci_pkg.sv]
package pci_pkg;
  localparam int          AW         = 32;
  localparam int          CTL_FRAME  = 0;
  localparam int          CTL_IRDY   = 1;
  localparam int          CTL_TRDY   = 2;
  localparam int          CTL_DEVSEL = 3;
  localparam logic [3:0]  BE_ALL     = 4'h0;
  localparam logic [3:0]  BE_NONE    = 4'hf;
  localparam logic [3:0]  CMD_MEM_RD = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR = 4'h7;
  localparam logic [3:0]  CMD_CFG_RD = 4'ha;
  localparam logic [3:0]  CMD_CFG_WR = 4'hb;
  // upper address half-word that selects each device window
  localparam logic [15:0] REG_WIN    = 16'h0001;
  localparam logic [15:0] LPB_WIN    = 16'h0002;
  // target read wait states beyond the turnaround; all writes take none
  localparam logic [1:0]  CFG_RD_WAITS = 2'h2;
  localparam logic [1:0]  REG_RD_WAITS = 2'h3;
  localparam logic [1:0]  LPB_RD_WAITS = 2'h3;
  // initiator wait in the first data cycle of a chained transaction
  localparam logic        FBB_WAITS  = 1'b1;
  localparam logic [2:0]  ABORT_CYC  = 3'h5;
  localparam logic [31:0] AD_IDLE    = 32'hffff_ffff;
  localparam logic [31:0] WORD_STEP  = 32'h4;

  typedef enum logic [1:0] {SP_CFG = 2'b00, SP_REG = 2'b01, SP_LPB = 2'b10} space_t;
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_ADDR = 2'b01, M_DATA = 2'b10,
                            M_END = 2'b11} mst_t;
  typedef enum logic [1:0] {T_IDLE = 2'b00, T_WAIT = 2'b01, T_DATA = 2'b10,
                            T_BACK = 2'b11} tgt_t;

  function automatic logic is_rd(input logic [3:0] c);
    return !c[0];
  endfunction

  function automatic logic is_mem(input logic [3:0] c);
    return c[3:1] == CMD_MEM_RD[3:1];
  endfunction

  function automatic logic dev_hit(input logic [3:0] c, input logic [31:0] a);
    return (c[3:1] == CMD_CFG_RD[3:1]) ||
           (is_mem(c) && (a[31:16] == REG_WIN || a[31:16] == LPB_WIN));
  endfunction
endpackage

// [src/pci_device_end.sv]
// Overview of operation
// - address and command in first FRAME clock
// - byte enables mark lanes each data phase
// - read: initiator releases AD, one turnaround
// - TRDY after DEVSEL; read data after turnaround
// - read target keeps AD drivers until end
// - word moves only when IRDY and TRDY
// - FRAME drops only with IRDY, marks last
// - write data follows address; target may wait
// - initiator wait: data held, enables withdrawn
// - DMA bursts keep IRDY asserted, no waits
// - chained transaction: one wait, first data only
// - config reads two waits, writes none
// - register/local bus reads three, writes none
// - answer config, register and local bus accesses
// - DMA engine masters host memory bursts
// - demultiplexed mode: PAR driven low always
`timescale 1ns/1ps
module pci_device_end #(
  parameter int LW = 8
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  pci_if.dev                 bus,
  input  wire logic          dma_start,
  input  wire logic          dma_write,
  input  wire logic          dma_fbb,
  input  wire logic [31:0]   dma_addr,
  input  wire logic [LW-1:0] dma_len,
  input  wire logic [31:0]   dma_wdata,
  output logic               dma_busy,
  output logic               dma_take,
  output logic               dma_rvalid,
  output logic [31:0]        dma_rdata,
  output logic               dma_done,
  output logic               tgt_req,
  output logic               tgt_we,
  output pci_pkg::space_t    tgt_space,
  output logic [31:0]        tgt_addr,
  output logic [31:0]        tgt_wdata,
  output logic [3:0]         tgt_be,
  input  wire logic [31:0]   tgt_rdata
);
  logic frame, irdy, trdy, devsel, gnt, addr_ph, txn_q, txn_d;
  assign frame  = !bus.ctl[pci_pkg::CTL_FRAME];
  assign irdy   = !bus.ctl[pci_pkg::CTL_IRDY];
  assign trdy   = !bus.ctl[pci_pkg::CTL_TRDY];
  assign devsel = !bus.ctl[pci_pkg::CTL_DEVSEL];
  assign gnt    = !bus.gnt_n;
  assign addr_ph = frame && !txn_q;

  ////////////////////////////////////////////////////////////////////////////
  // initiator
  pci_pkg::mst_t m_q, m_d;
  logic          pend_q, pend_d, pw_q, pw_d, pf_q, pf_d;
  logic [31:0]   pa_q, pa_d, mad_q, mad_d, rdat_q, rdat_d;
  logic [LW-1:0] pl_q, pl_d, left_q, left_d;
  logic          wr_q, wr_d, mw_q, mw_d, rv_q, rv_d, done_q, done_d;
  logic          m_irdy, m_frame, last, mx, launch, bus_idle;

  assign m_irdy   = (m_q == pci_pkg::M_DATA) && !mw_q;
  assign last     = left_q == LW'(1);
  assign m_frame  = (m_q == pci_pkg::M_ADDR) ||
                    (m_q == pci_pkg::M_DATA && !(last && m_irdy));
  assign mx       = m_irdy && trdy;
  assign bus_idle = !frame && !irdy && !txn_q;
  // a chained request reuses the bus straight after the last data phase
  assign launch   = pend_q && gnt &&
                    ((m_q == pci_pkg::M_IDLE && bus_idle) ||
                     (m_q == pci_pkg::M_DATA && mx && last && pf_q));
  assign dma_take = wr_q && ((m_q == pci_pkg::M_ADDR) ||
                    (m_q == pci_pkg::M_DATA && mx && !last));

  always_comb begin
    m_d = m_q;
    pend_d = pend_q;
    pw_d = pw_q;
    pf_d = pf_q;
    pa_d = pa_q;
    pl_d = pl_q;
    left_d = left_q;
    wr_d = wr_q;
    mw_d = mw_q;
    mad_d = mad_q;
    rdat_d = rdat_q;
    rv_d = 1'b0;
    done_d = 1'b0;
    if (dma_start && !pend_q) begin
      pend_d = 1'b1;
      pw_d = dma_write;
      pf_d = dma_fbb;
      pa_d = dma_addr;
      pl_d = dma_len;
    end
    if (dma_take) begin
      mad_d = dma_wdata;
    end
    case (m_q)
      pci_pkg::M_IDLE: ;
      pci_pkg::M_ADDR: m_d = pci_pkg::M_DATA;
      pci_pkg::M_DATA: begin
        mw_d = 1'b0;
        if (mx) begin
          left_d = left_q - 1'b1;
          rv_d = !wr_q;
          if (!wr_q) begin
            rdat_d = bus.ad;
          end
          if (last) begin
            done_d = 1'b1;
            m_d = pci_pkg::M_END;
          end
        end
      end
      pci_pkg::M_END: m_d = pci_pkg::M_IDLE;
      default: m_d = pci_pkg::M_IDLE;
    endcase
    if (launch) begin
      m_d = pci_pkg::M_ADDR;
      pend_d = 1'b0;
      wr_d = pw_q;
      left_d = pl_q;
      mad_d = pa_q;
      mw_d = (m_q == pci_pkg::M_DATA) && pci_pkg::FBB_WAITS;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_q <= pci_pkg::M_IDLE;
      pend_q <= 1'b0;
      pw_q <= 1'b0;
      pf_q <= 1'b0;
      pa_q <= 32'h0;
      pl_q <= '0;
      left_q <= '0;
      wr_q <= 1'b0;
      mw_q <= 1'b0;
      mad_q <= 32'h0;
      rdat_q <= 32'h0;
      rv_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      m_q <= m_d;
      pend_q <= pend_d;
      pw_q <= pw_d;
      pf_q <= pf_d;
      pa_q <= pa_d;
      pl_q <= pl_d;
      left_q <= left_d;
      wr_q <= wr_d;
      mw_q <= mw_d;
      mad_q <= mad_d;
      rdat_q <= rdat_d;
      rv_q <= rv_d;
      done_q <= done_d;
    end
  end

  assign dma_busy   = pend_q;
  assign dma_rvalid = rv_q;
  assign dma_rdata  = rdat_q;
  assign dma_done   = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // target
  pci_pkg::tgt_t   t_q, t_d;
  pci_pkg::space_t sp_q, sp_d, sp_dec;
  logic            tw_q, tw_d, toe_q, toe_d, treq_q, treq_d, load, zero;
  logic [31:0]     taddr_q, taddr_d, twd_q, twd_d, tad_q, tad_d;
  logic [3:0]      tbe_q, tbe_d;
  logic [1:0]      waits;

  always_comb begin
    if (!pci_pkg::is_mem(bus.cbe)) begin
      sp_dec = pci_pkg::SP_CFG;
    end else if (bus.ad[31:16] == pci_pkg::REG_WIN) begin
      sp_dec = pci_pkg::SP_REG;
    end else begin
      sp_dec = pci_pkg::SP_LPB;
    end
  end

  // a read burst pays the same wait for every word
  assign waits = (sp_q == pci_pkg::SP_CFG) ? pci_pkg::CFG_RD_WAITS :
                 (sp_q == pci_pkg::SP_REG) ? pci_pkg::REG_RD_WAITS :
                 pci_pkg::LPB_RD_WAITS;

  wait_cnt #(.W(2)) u_wait (
    .clk    (clk),
    .resetn (resetn),
    .load   (load),
    .value  ((t_q == pci_pkg::T_IDLE) ? ((sp_dec == pci_pkg::SP_CFG) ?
             pci_pkg::CFG_RD_WAITS : pci_pkg::REG_RD_WAITS) : waits),
    .zero   (zero)
  );

  always_comb begin
    t_d = t_q;
    sp_d = sp_q;
    tw_d = tw_q;
    toe_d = toe_q;
    taddr_d = taddr_q;
    twd_d = twd_q;
    tbe_d = tbe_q;
    tad_d = tad_q;
    treq_d = 1'b0;
    load = 1'b0;
    txn_d = txn_q;
    if (addr_ph) begin
      txn_d = 1'b1;
    end else if (irdy && trdy && !frame) begin
      txn_d = 1'b0;
    end
    if (treq_q && tw_q) begin
      taddr_d = taddr_q + pci_pkg::WORD_STEP;
    end
    case (t_q)
      pci_pkg::T_IDLE, pci_pkg::T_BACK: begin
        t_d = pci_pkg::T_IDLE;
        toe_d = 1'b0;
        if (addr_ph && m_q == pci_pkg::M_IDLE &&
            pci_pkg::dev_hit(bus.cbe, bus.ad)) begin
          sp_d = sp_dec;
          taddr_d = bus.ad;
          tw_d = !pci_pkg::is_rd(bus.cbe);
          if (pci_pkg::is_rd(bus.cbe)) begin
            t_d = pci_pkg::T_WAIT;
            treq_d = 1'b1;
            load = 1'b1;
          end else begin
            t_d = pci_pkg::T_DATA;
          end
        end
      end
      pci_pkg::T_WAIT: begin
        if (zero) begin
          t_d = pci_pkg::T_DATA;
          tad_d = tgt_rdata;
          toe_d = 1'b1;
        end
      end
      pci_pkg::T_DATA: begin
        if (irdy) begin
          if (tw_q) begin
            treq_d = 1'b1;
            twd_d = bus.ad;
            tbe_d = bus.cbe;
          end
          if (!frame) begin
            t_d = pci_pkg::T_BACK;
          end else if (!tw_q) begin
            t_d = pci_pkg::T_WAIT;
            taddr_d = taddr_q + pci_pkg::WORD_STEP;
            treq_d = 1'b1;
            load = 1'b1;
          end
        end
      end
      default: t_d = pci_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      t_q <= pci_pkg::T_IDLE;
      sp_q <= pci_pkg::SP_CFG;
      tw_q <= 1'b0;
      toe_q <= 1'b0;
      treq_q <= 1'b0;
      taddr_q <= 32'h0;
      twd_q <= 32'h0;
      tbe_q <= pci_pkg::BE_NONE;
      tad_q <= 32'h0;
      txn_q <= 1'b0;
    end else begin
      t_q <= t_d;
      sp_q <= sp_d;
      tw_q <= tw_d;
      toe_q <= toe_d;
      treq_q <= treq_d;
      taddr_q <= taddr_d;
      twd_q <= twd_d;
      tbe_q <= tbe_d;
      tad_q <= tad_d;
      txn_q <= txn_d;
    end
  end

  assign tgt_req   = treq_q;
  assign tgt_we    = tw_q;
  assign tgt_space = sp_q;
  assign tgt_addr  = taddr_q;
  assign tgt_wdata = twd_q;
  assign tgt_be    = tbe_q;

  ////////////////////////////////////////////////////////////////////////////
  // pins
  logic m_on, t_on, m_ad;
  assign m_on = m_q != pci_pkg::M_IDLE;
  assign t_on = t_q != pci_pkg::T_IDLE;
  assign m_ad = (m_q == pci_pkg::M_ADDR) || (m_q == pci_pkg::M_DATA && wr_q);
  assign bus.dev_ctl_o  = {!(t_q == pci_pkg::T_WAIT || t_q == pci_pkg::T_DATA),
                           !(t_q == pci_pkg::T_DATA), !m_irdy, !m_frame};
  assign bus.dev_ctl_oe = {t_on, t_on, m_on, m_on};
  assign bus.dev_ad_o   = m_ad ? mad_q : tad_q;
  assign bus.dev_ad_oe  = m_ad || toe_q;
  assign bus.dev_cbe_o  = (m_q == pci_pkg::M_ADDR) ?
                          (wr_q ? pci_pkg::CMD_MEM_WR : pci_pkg::CMD_MEM_RD) :
                          (m_irdy ? pci_pkg::BE_ALL : pci_pkg::BE_NONE);
  assign bus.dev_cbe_oe = m_q == pci_pkg::M_ADDR || m_q == pci_pkg::M_DATA;
  // parity is not generated in the demultiplexed configuration
  assign bus.par_o      = 1'b0;
  assign bus.par_oe     = 1'b1;
  assign bus.req_n      = !pend_q;
endmodule

// [src/pci_host_end.sv]
`timescale 1ns/1ps
module pci_host_end (
  input  wire logic        clk,
  input  wire logic        resetn,
  pci_if.host              bus,
  input  wire logic        cmd_start,
  input  wire logic [3:0]  cmd_code,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic [3:0]  cmd_be,
  output logic             cmd_busy,
  output logic             cmd_done,
  output logic             cmd_abort,
  output logic [31:0]      cmd_rdata,
  output logic             mem_wr,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic [3:0]       mem_be,
  input  wire logic [31:0] mem_rdata
);
  logic frame, irdy, trdy, devsel, txn_q;
  assign frame  = !bus.ctl[pci_pkg::CTL_FRAME];
  assign irdy   = !bus.ctl[pci_pkg::CTL_IRDY];
  assign trdy   = !bus.ctl[pci_pkg::CTL_TRDY];
  assign devsel = !bus.ctl[pci_pkg::CTL_DEVSEL];

  ////////////////////////////////////////////////////////////////////////////
  // single-word initiator and arbiter
  pci_pkg::mst_t h_q, h_d;
  logic          pend_q, pend_d, gnt_q, gnt_d, done_q, done_d, ab_q, ab_d;
  logic [3:0]    code_q, code_d, be_q, be_d;
  logic [31:0]   had_q, had_d, wd_q, wd_d, rd_q, rd_d;
  logic [2:0]    cnt_q, cnt_d;

  always_comb begin
    h_d = h_q;
    pend_d = pend_q;
    code_d = code_q;
    be_d = be_q;
    had_d = had_q;
    wd_d = wd_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    ab_d = ab_q;
    done_d = 1'b0;
    // the grant is given to the requesting device only while this side is quiet
    gnt_d = !bus.req_n && h_q == pci_pkg::M_IDLE && (gnt_q || !pend_q);
    if (cmd_start && !pend_q) begin
      pend_d = 1'b1;
      code_d = cmd_code;
      be_d = cmd_be;
      had_d = cmd_addr;
      wd_d = cmd_wdata;
    end
    case (h_q)
      pci_pkg::M_IDLE: begin
        if (pend_q && !gnt_q && !frame && !irdy && !txn_q) begin
          h_d = pci_pkg::M_ADDR;
        end
      end
      pci_pkg::M_ADDR: begin
        h_d = pci_pkg::M_DATA;
        cnt_d = 3'h0;
        if (!pci_pkg::is_rd(code_q)) begin
          had_d = wd_q;
        end
      end
      pci_pkg::M_DATA: begin
        cnt_d = cnt_q + 3'h1;
        if (trdy) begin
          rd_d = bus.ad;
          ab_d = 1'b0;
          done_d = 1'b1;
          h_d = pci_pkg::M_END;
        end else if (!devsel && cnt_q == pci_pkg::ABORT_CYC) begin
          rd_d = pci_pkg::AD_IDLE;
          ab_d = 1'b1;
          done_d = 1'b1;
          h_d = pci_pkg::M_END;
        end
      end
      pci_pkg::M_END: begin
        h_d = pci_pkg::M_IDLE;
        pend_d = 1'b0;
      end
      default: h_d = pci_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_q <= pci_pkg::M_IDLE;
      pend_q <= 1'b0;
      gnt_q <= 1'b0;
      done_q <= 1'b0;
      ab_q <= 1'b0;
      code_q <= pci_pkg::CMD_MEM_RD;
      be_q <= pci_pkg::BE_ALL;
      had_q <= 32'h0;
      wd_q <= 32'h0;
      rd_q <= 32'h0;
      cnt_q <= 3'h0;
    end else begin
      h_q <= h_d;
      pend_q <= pend_d;
      gnt_q <= gnt_d;
      done_q <= done_d;
      ab_q <= ab_d;
      code_q <= code_d;
      be_q <= be_d;
      had_q <= had_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  assign cmd_busy  = pend_q;
  assign cmd_done  = done_q;
  assign cmd_abort = ab_q;
  assign cmd_rdata = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // host memory target, one wait per read word after the first
  pci_pkg::tgt_t s_q, s_d;
  logic          sw_q, sw_d, soe_q, soe_d, mwr_q, mwr_d, txn_d;
  logic [31:0]   sa_q, sa_d, sad_q, sad_d, swd_q, swd_d;
  logic [3:0]    sbe_q, sbe_d;

  always_comb begin
    s_d = s_q;
    sw_d = sw_q;
    soe_d = soe_q;
    sa_d = sa_q;
    sad_d = sad_q;
    swd_d = swd_q;
    sbe_d = sbe_q;
    mwr_d = 1'b0;
    txn_d = txn_q;
    if (frame && !txn_q) begin
      txn_d = 1'b1;
    end else if (irdy && trdy && !frame) begin
      txn_d = 1'b0;
    end
    if (mwr_q) begin
      sa_d = sa_q + pci_pkg::WORD_STEP;
    end
    case (s_q)
      pci_pkg::T_IDLE, pci_pkg::T_BACK: begin
        s_d = pci_pkg::T_IDLE;
        soe_d = 1'b0;
        // a chained address phase may land in the back-off cycle
        if (frame && !txn_q && h_q == pci_pkg::M_IDLE && pci_pkg::is_mem(bus.cbe) &&
            !pci_pkg::dev_hit(bus.cbe, bus.ad)) begin
          sa_d = bus.ad;
          sw_d = !pci_pkg::is_rd(bus.cbe);
          s_d = pci_pkg::is_rd(bus.cbe) ? pci_pkg::T_WAIT : pci_pkg::T_DATA;
        end
      end
      pci_pkg::T_WAIT: begin
        s_d = pci_pkg::T_DATA;
        sad_d = mem_rdata;
        soe_d = 1'b1;
      end
      pci_pkg::T_DATA: begin
        if (irdy) begin
          if (sw_q) begin
            mwr_d = 1'b1;
            swd_d = bus.ad;
            sbe_d = bus.cbe;
          end
          if (!frame) begin
            s_d = pci_pkg::T_BACK;
          end else if (!sw_q) begin
            s_d = pci_pkg::T_WAIT;
            sa_d = sa_q + pci_pkg::WORD_STEP;
          end
        end
      end
      default: s_d = pci_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= pci_pkg::T_IDLE;
      sw_q <= 1'b0;
      soe_q <= 1'b0;
      mwr_q <= 1'b0;
      sa_q <= 32'h0;
      sad_q <= 32'h0;
      swd_q <= 32'h0;
      sbe_q <= pci_pkg::BE_NONE;
      txn_q <= 1'b0;
    end else begin
      s_q <= s_d;
      sw_q <= sw_d;
      soe_q <= soe_d;
      mwr_q <= mwr_d;
      sa_q <= sa_d;
      sad_q <= sad_d;
      swd_q <= swd_d;
      sbe_q <= sbe_d;
      txn_q <= txn_d;
    end
  end

  assign mem_wr    = mwr_q;
  assign mem_addr  = sa_q;
  assign mem_wdata = swd_q;
  assign mem_be    = sbe_q;

  ////////////////////////////////////////////////////////////////////////////
  // pins
  logic h_on, s_on, h_ad;
  assign h_on = h_q != pci_pkg::M_IDLE;
  assign s_on = s_q != pci_pkg::T_IDLE;
  assign h_ad = h_q == pci_pkg::M_ADDR ||
                (h_q == pci_pkg::M_DATA && !pci_pkg::is_rd(code_q));
  // single word: FRAME is already released while IRDY is asserted
  assign bus.host_ctl_o  = {!(s_q == pci_pkg::T_WAIT || s_q == pci_pkg::T_DATA),
                            !(s_q == pci_pkg::T_DATA), !(h_q == pci_pkg::M_DATA),
                            !(h_q == pci_pkg::M_ADDR)};
  assign bus.host_ctl_oe = {s_on, s_on, h_on, h_on};
  assign bus.host_ad_o   = h_ad ? had_q : sad_q;
  assign bus.host_ad_oe  = h_ad || soe_q;
  assign bus.host_cbe_o  = (h_q == pci_pkg::M_ADDR) ? code_q : be_q;
  assign bus.host_cbe_oe = h_q == pci_pkg::M_ADDR || h_q == pci_pkg::M_DATA;
  assign bus.gnt_n       = !gnt_q;
endmodule

// [src/wait_cnt.sv]
`timescale 1ns/1ps
module wait_cnt #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              zero
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign zero = cnt_q == '0;
endmodule
